// File: rtl/slice_addsub.sv
// One 16-bit adder/subtractor half of the slice
`timescale 1ns/1ps

module slice_addsub
(
    input  wire logic [15:0] augend,
    input  wire logic [15:0] addend,
    input  wire logic        carry_in,
    input  wire logic        sub_select,
    output logic      [15:0] sum,
    output logic             carry_out
);

    logic [16:0] wide;

    // Add gives W+X+cin, subtract gives W-X-cin; bit 16 is carry or borrow
    always_comb
    begin
        if (sub_select)
        begin
            wide = {1'b0, augend} - {1'b0, addend} - {16'h0000, carry_in};
        end
        else
        begin
            wide = {1'b0, augend} + {1'b0, addend} + {16'h0000, carry_in};
        end
        sum       = wide[15:0];
        carry_out = wide[16];
    end

endmodule

// File: rtl/slice_consts.svh
// Offsets, widths, reset value and encodings of the arithmetic slice
`ifndef SLICE_CONSTS_SVH
`define SLICE_CONSTS_SVH

`define ADDR_W        8
`define OP_W          16
`define CFG_W         13
`define CFG_ADDR      8'h00
`define RESULT_ADDR   8'h04
`define CFG_RESET     13'h0000
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`define CSRC_ZERO     2'h0
`define CSRC_ONE      2'h1
`define CSRC_CASCADE  2'h2
`define CSRC_FABRIC   2'h3
`define BYTE_LANES    4

`endif

// File: rtl/slice_pkg.sv
// Types shared by the arithmetic slice files
`include "slice_consts.svh"

package slice_pkg;

    typedef enum logic [1:0]
    {
        MODE_MULT   = 2'h0,
        MODE_ADDSUB = 2'h1,
        MODE_ACCUM  = 2'h2,
        MODE_MAC    = 2'h3
    } mode_type;

    typedef struct packed {
        logic       b_signed;
        logic       a_signed;
        logic [1:0] upper_carry_source;
        logic [1:0] lower_carry_source;
        mode_type   mode;
        logic       pipe_en;
        logic       d_reg_en;
        logic       c_reg_en;
        logic       b_reg_en;
        logic       a_reg_en;
    } cfg_type;

    typedef struct packed {
        logic [`OP_W-1:0] a;
        logic [`OP_W-1:0] b;
        logic [`OP_W-1:0] c;
        logic [`OP_W-1:0] d;
    } operands_type;

    typedef struct packed {
        logic operand_a_hold;
        logic operand_b_hold;
        logic operand_c_hold;
        logic operand_d_hold;
        logic upper_input_reset;
        logic lower_input_reset;
        logic upper_accum_reset;
        logic lower_accum_reset;
        logic upper_accum_load;
        logic lower_accum_load;
        logic upper_sub_select;
        logic lower_sub_select;
        logic upper_accum_hold;
        logic lower_accum_hold;
    } controls_type;

    typedef struct packed {
        cfg_type             cfg;
        logic [`OP_W-1:0]    a_q;
        logic [`OP_W-1:0]    b_q;
        logic [`OP_W-1:0]    c_q;
        logic [`OP_W-1:0]    d_q;
        logic [`OP_W-1:0]    top_pipe;
        logic [`OP_W-1:0]    bot_pipe;
        logic [31:0]         product;
        logic [31:0]         accum;
        logic                carry_q;
        logic                aw_full;
        logic [`ADDR_W-1:0]  aw_addr;
        logic                w_full;
        logic [31:0]         w_data;
        logic [3:0]          w_strb;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                rvalid;
        logic [31:0]         rdata;
        logic [1:0]          rresp;
    } state_type;

endpackage

// File: rtl/slice_top.sv
// Multiply/add/accumulate slice with AXI4-Lite configuration port
`timescale 1ns/1ps
`include "slice_consts.svh"

module slice_top
#(
    parameter logic [`CFG_W-1:0] CFG_DEFAULT = `CFG_RESET
)
(
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic [`ADDR_W-1:0]        awaddr,
    input  wire logic                      awvalid,
    output logic                           awready,
    input  wire logic [31:0]               wdata,
    input  wire logic [3:0]                wstrb,
    input  wire logic                      wvalid,
    output logic                           wready,
    output logic [1:0]                     bresp,
    output logic                           bvalid,
    input  wire logic                      bready,
    input  wire logic [`ADDR_W-1:0]        araddr,
    input  wire logic                      arvalid,
    output logic                           arready,
    output logic [31:0]                    rdata,
    output logic [1:0]                     rresp,
    output logic                           rvalid,
    input  wire logic                      rready,
    input  wire logic                      clk_enable,
    input  wire slice_pkg::operands_type   ops,
    input  wire slice_pkg::controls_type   ctrl,
    input  wire logic                      cascade_carry_in,
    input  wire logic                      fabric_carry_input,
    output logic [31:0]                    result,
    output logic                           cascade_carry_out
);

    // ==========================================================
    // State and combinational nets
    slice_pkg::state_type    s;
    slice_pkg::state_type    next_s;
    logic [`OP_W-1:0]        a_op;
    logic [`OP_W-1:0]        b_op;
    logic [`OP_W-1:0]        c_op;
    logic [`OP_W-1:0]        d_op;
    logic [`OP_W-1:0]        mult_a;
    logic [`OP_W-1:0]        mult_b;
    logic signed [16:0]      mult_a_ext;
    logic signed [16:0]      mult_b_ext;
    logic signed [33:0]      mult_full;
    logic [31:0]             product_comb;
    logic [31:0]             mult_out;
    logic [`OP_W-1:0]        upper_w;
    logic [`OP_W-1:0]        upper_x;
    logic [`OP_W-1:0]        lower_y;
    logic [`OP_W-1:0]        lower_z;
    logic [`OP_W-1:0]        upper_sum;
    logic [`OP_W-1:0]        lower_sum;
    logic                    upper_carry_in;
    logic                    lower_carry_in;
    logic                    upper_carry_out;
    logic                    lower_carry_out;
    logic [31:0]             cfg_word;
    logic [31:0]             merged;
    logic                    write_go;

    function automatic logic pick_carry(input logic [1:0] src, input logic chain, input logic fabric);
        case (src)
            `CSRC_ZERO:    pick_carry = 1'b0;
            `CSRC_ONE:     pick_carry = 1'b1;
            `CSRC_CASCADE: pick_carry = chain;
            `CSRC_FABRIC:  pick_carry = fabric;
            default:       pick_carry = 1'b0;
        endcase
    endfunction

    // ==========================================================
    // Bus handshakes and outputs
    assign awready           = !s.aw_full && !s.bvalid;
    assign wready            = !s.w_full && !s.bvalid;
    assign arready           = !s.rvalid;
    assign bvalid            = s.bvalid;
    assign bresp             = s.bresp;
    assign rvalid            = s.rvalid;
    assign rdata             = s.rdata;
    assign rresp             = s.rresp;
    assign result            = s.accum;
    assign cascade_carry_out = s.carry_q;
    assign write_go          = s.aw_full && s.w_full;
    assign cfg_word          = {{(32-`CFG_W){1'b0}}, s.cfg};

    // Byte lanes of a configuration write merge with the current value
    genvar lane;
    generate
        for (lane = 0; lane < `BYTE_LANES; lane++)
        begin : g_lane
            assign merged[8*lane +: 8] = s.w_strb[lane] ? s.w_data[8*lane +: 8] : cfg_word[8*lane +: 8];
        end
    endgenerate

    // ==========================================================
    // Operand paths and multiplier
    assign a_op = s.cfg.a_reg_en ? s.a_q : ops.a;
    assign b_op = s.cfg.b_reg_en ? s.b_q : ops.b;
    assign c_op = s.cfg.c_reg_en ? s.c_q : ops.c;
    assign d_op = s.cfg.d_reg_en ? s.d_q : ops.d;

    assign mult_a       = s.cfg.pipe_en ? s.top_pipe : a_op;
    assign mult_b       = s.cfg.pipe_en ? s.bot_pipe : b_op;
    assign mult_a_ext   = signed'({s.cfg.a_signed & mult_a[15], mult_a});
    assign mult_b_ext   = signed'({s.cfg.b_signed & mult_b[15], mult_b});
    assign mult_full    = mult_a_ext * mult_b_ext;
    assign product_comb = mult_full[31:0];
    assign mult_out     = s.cfg.pipe_en ? s.product : product_comb;

    // ==========================================================
    // Adder inputs chosen by the configured function
    always_comb
    begin
        upper_w = s.accum[31:16];
        upper_x = a_op;
        lower_y = s.accum[15:0];
        lower_z = b_op;
        case (s.cfg.mode)
            slice_pkg::MODE_MULT:
            begin
                upper_w = 16'h0000;
                upper_x = mult_out[31:16];
                lower_y = 16'h0000;
                lower_z = mult_out[15:0];
            end
            slice_pkg::MODE_ADDSUB:
            begin
                upper_w = c_op;
                lower_y = d_op;
            end
            slice_pkg::MODE_ACCUM:
            begin
                upper_x = a_op;
                lower_z = b_op;
            end
            slice_pkg::MODE_MAC:
            begin
                upper_x = mult_out[31:16];
                lower_z = mult_out[15:0];
            end
            default:
            begin
                upper_w = 16'h0000;
                lower_y = 16'h0000;
            end
        endcase
    end

    assign lower_carry_in = pick_carry(s.cfg.lower_carry_source, cascade_carry_in, fabric_carry_input);
    assign upper_carry_in = pick_carry(s.cfg.upper_carry_source, lower_carry_out, fabric_carry_input);

    slice_addsub u_upper
    (
        .augend     (upper_w),
        .addend     (upper_x),
        .carry_in   (upper_carry_in),
        .sub_select (ctrl.upper_sub_select),
        .sum        (upper_sum),
        .carry_out  (upper_carry_out)
    );

    slice_addsub u_lower
    (
        .augend     (lower_y),
        .addend     (lower_z),
        .carry_in   (lower_carry_in),
        .sub_select (ctrl.lower_sub_select),
        .sum        (lower_sum),
        .carry_out  (lower_carry_out)
    );

    // ==========================================================
    // Next state
    always_comb
    begin
        next_s = s;
        if (awvalid && awready)
        begin
            next_s.aw_full = 1'b1;
            next_s.aw_addr = awaddr;
        end
        if (wvalid && wready)
        begin
            next_s.w_full = 1'b1;
            next_s.w_data = wdata;
            next_s.w_strb = wstrb;
        end
        if (write_go)
        begin
            next_s.aw_full = 1'b0;
            next_s.w_full  = 1'b0;
            next_s.bvalid  = 1'b1;
            if ({s.aw_addr[`ADDR_W-1:2], 2'b00} == `CFG_ADDR)
            begin
                next_s.cfg   = slice_pkg::cfg_type'(merged[`CFG_W-1:0]);
                next_s.bresp = `RESP_OKAY;
            end
            else
            begin
                next_s.bresp = `RESP_SLVERR;
            end
        end
        else if (s.bvalid && bready)
        begin
            next_s.bvalid = 1'b0;
        end
        if (arvalid && arready)
        begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = `RESP_OKAY;
            case ({araddr[`ADDR_W-1:2], 2'b00})
                `CFG_ADDR:    next_s.rdata = cfg_word;
                `RESULT_ADDR: next_s.rdata = s.accum;
                default:
                begin
                    next_s.rdata = 32'h0000_0000;
                    next_s.rresp = `RESP_SLVERR;
                end
            endcase
        end
        else if (s.rvalid && rready)
        begin
            next_s.rvalid = 1'b0;
        end

        // Slice storage moves only on an enabled edge; resets win over hold and load
        if (clk_enable)
        begin
            if (ctrl.upper_input_reset)
                next_s.a_q = 16'h0000;
            else if (!ctrl.operand_a_hold)
                next_s.a_q = ops.a;
            if (ctrl.lower_input_reset)
                next_s.b_q = 16'h0000;
            else if (!ctrl.operand_b_hold)
                next_s.b_q = ops.b;
            if (ctrl.upper_input_reset || ctrl.lower_input_reset)
                next_s.c_q = 16'h0000;
            else if (!ctrl.operand_c_hold)
                next_s.c_q = ops.c;
            if (!ctrl.operand_d_hold)
                next_s.d_q = ops.d;
            next_s.top_pipe = ctrl.upper_input_reset ? 16'h0000 : a_op;
            next_s.bot_pipe = ctrl.lower_input_reset ? 16'h0000 : b_op;
            next_s.product  = ctrl.lower_input_reset ? 32'h0000_0000 : product_comb;
            if (ctrl.upper_accum_reset)
            begin
                next_s.accum[31:16] = 16'h0000;
                next_s.carry_q      = 1'b0;
            end
            else if (!ctrl.upper_accum_hold)
            begin
                next_s.accum[31:16] = ctrl.upper_accum_load ? c_op : upper_sum;
                next_s.carry_q      = upper_carry_out;
            end
            if (ctrl.lower_accum_reset)
                next_s.accum[15:0] = 16'h0000;
            else if (!ctrl.lower_accum_hold)
                next_s.accum[15:0] = ctrl.lower_accum_load ? d_op : lower_sum;
        end

        if (!aresetn)
        begin
            next_s     = '0;
            next_s.cfg = slice_pkg::cfg_type'(CFG_DEFAULT);
        end
    end

    always_ff @(posedge aclk)
    begin
        s <= next_s;
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_ce_freeze: assert property (!clk_enable |=> $stable(s.accum) && $stable(s.a_q) && $stable(s.product))
        else $error("slice storage changed with clock enable low");
    a_a_hold: assert property (clk_enable && ctrl.operand_a_hold && !ctrl.upper_input_reset |=> $stable(s.a_q))
        else $error("A register changed while held");
    a_a_load: assert property (clk_enable && !ctrl.operand_a_hold && !ctrl.upper_input_reset
                               |=> s.a_q == $past(ops.a))
        else $error("A register missed a load");
    a_b_hold: assert property (clk_enable && ctrl.operand_b_hold && !ctrl.lower_input_reset |=> $stable(s.b_q))
        else $error("B register changed while held");
    a_c_load: assert property (clk_enable && !ctrl.operand_c_hold && !ctrl.upper_input_reset
                               && !ctrl.lower_input_reset |=> s.c_q == $past(ops.c))
        else $error("C register missed a load");
    a_d_hold: assert property (clk_enable && ctrl.operand_d_hold |=> $stable(s.d_q))
        else $error("D register changed while held");
    a_upper_clear: assert property (clk_enable && ctrl.upper_input_reset
                                    |=> s.a_q == 16'h0000 && s.c_q == 16'h0000 && s.top_pipe == 16'h0000)
        else $error("upper input reset did not clear");
    a_lower_clear: assert property (clk_enable && ctrl.lower_input_reset
                                    |=> s.b_q == 16'h0000 && s.bot_pipe == 16'h0000 && s.product == 32'h0)
        else $error("lower input reset did not clear");
    a_acc_hi_clear: assert property (clk_enable && ctrl.upper_accum_reset && !ctrl.lower_accum_reset
                                     && ctrl.lower_accum_hold
                                     |=> result[31:16] == 16'h0000 && $stable(result[15:0]))
        else $error("upper accumulator reset wrong");
    a_acc_lo_clear: assert property (clk_enable && ctrl.lower_accum_reset && ctrl.upper_accum_hold
                                     && !ctrl.upper_accum_reset
                                     |=> result[15:0] == 16'h0000 && $stable(result[31:16]))
        else $error("lower accumulator reset wrong");
    a_acc_hi_load: assert property (clk_enable && !ctrl.upper_accum_reset && !ctrl.upper_accum_hold
                                    && ctrl.upper_accum_load |=> result[31:16] == $past(c_op))
        else $error("upper accumulator did not take C");
    a_acc_lo_load: assert property (clk_enable && !ctrl.lower_accum_reset && !ctrl.lower_accum_hold
                                    && ctrl.lower_accum_load |=> result[15:0] == $past(d_op))
        else $error("lower accumulator did not take D");
    a_acc_hi_hold: assert property (clk_enable && ctrl.upper_accum_hold && !ctrl.upper_accum_reset
                                    |=> $stable(result[31:16]) && $stable(cascade_carry_out))
        else $error("upper accumulator changed while held");
    a_lo_carry: assert property (s.cfg.lower_carry_source == `CSRC_CASCADE
                                 |-> lower_carry_in == cascade_carry_in)
        else $error("lower carry not taken from cascade");
    a_bus_answer: assert property (awvalid && awready ##0 wvalid && wready |=> ##1 bvalid)
        else $error("write answer late");

    c_mac_run: cover property (s.cfg.mode == slice_pkg::MODE_MAC && clk_enable [*3]);
    c_sub_borrow: cover property (clk_enable && ctrl.upper_sub_select && upper_carry_out);
    c_cfg_write: cover property (write_go && s.aw_addr == `CFG_ADDR);

endmodule

// File: sim/dsp_multiply_accumulate_slice_tb.sv
// Self-checking bench for the arithmetic slice
`timescale 1ns/1ps

module dsp_multiply_accumulate_slice_tb;

    typedef struct {logic [31:0] d; logic [1:0] r;} note_type;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, ce, cci, fci, ce_req, cco;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, result;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, carry_req;
    slice_pkg::operands_type ops, ops_req;
    slice_pkg::controls_type ctrl, ctrl_req;
    integer      n_mismatch = 0;
    integer      checks = 0;
    integer      seed = 5;
    note_type    rq[$];
    logic [1:0]  wq[$];
    note_type    note;

    slice_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .clk_enable(ce), .ops(ops), .ctrl(ctrl), .cascade_carry_in(cci),
        .fabric_carry_input(fci), .result(result), .cascade_carry_out(cco));

    fabric_model fab (.aclk(aclk), .ce_req(ce_req), .ops_req(ops_req), .ctrl_req(ctrl_req),
        .carry_req(carry_req), .clk_enable(ce), .ops(ops), .ctrl(ctrl), .cascade_carry_in(cci),
        .fabric_carry_input(fci));

    // ==========================================================
    // Clock, watchdog, verdict
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    initial
    begin
        #300000;
        n_mismatch++;
        report_and_stop();
    end

    task automatic report_and_stop;
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t data %h expected %h", $time, g, e);
        end
    endtask

    task automatic cmp2(input logic [1:0] g, input logic [1:0] e);
        checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t resp %h expected %h", $time, g, e);
        end
    endtask

    task automatic cmp1(input logic g, input logic e);
        checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t carry %b expected %b", $time, g, e);
        end
    endtask

    // ==========================================================
    // Bus master and slice stimulus
    task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        wq.push_back(er);
        @(posedge aclk);
        awaddr <= ad;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hf;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) aw_ok = 1'b1;
            if (wvalid && wready === 1'b1) w_ok = 1'b1;
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
        end
        while (!(aw_ok && w_ok));
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
        rq.push_back('{d, er});
        @(posedge aclk);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask

    // Gives the slice exactly one edge with the requested enable
    task automatic apply(input slice_pkg::operands_type o, input slice_pkg::controls_type c,
                         input logic e, input logic [1:0] cy);
        @(posedge aclk);
        ops_req <= o;
        ctrl_req <= c;
        ce_req <= e;
        carry_req <= cy;
        @(posedge aclk);
        ce_req <= 1'b0;
        @(posedge aclk);
    endtask

    // ==========================================================
    // Result monitor
    always @(posedge aclk)
    begin
        if (rvalid === 1'b1 && rready === 1'b1)
        begin
            note = rq.pop_front();
            cmp32(rdata, note.d);
            cmp2(rresp, note.r);
        end
        if (bvalid === 1'b1 && bready === 1'b1)
            cmp2(bresp, wq.pop_front());
    end

    // ==========================================================
    // Scenarios
    initial
    begin
        slice_pkg::operands_type o, p;
        slice_pkg::controls_type c, z;
        logic [1:0]  cy;
        logic [15:0] hi, lo;
        logic        cin;
        logic [16:0] hw;
        logic [31:0] sp, ex;
        {aresetn, awvalid, wvalid, bready, arvalid, rready, ce_req} = '0;
        {awaddr, araddr, wdata, wstrb, carry_req} = '0;
        ops_req = '0;
        ctrl_req = '0;
        z = '0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h04, 32'h0, 2'h0);
        rd(8'h08, 32'h0, 2'h2);
        wr(8'h04, 32'h1, 2'h2);
        c = '0;
        for (int s = 0; s < 8; s++)
        begin
            o = {$random(seed), $random(seed)};
            cy = 2'($random(seed));
            c.upper_sub_select = s[0];
            c.lower_sub_select = s[0];
            cin = (s[2:1] == 0) ? 1'b0 : (s[2:1] == 1) ? 1'b1 : (s[2:1] == 2) ? cy[1] : cy[0];
            wr(8'h00, 32'h20 | (s[2:1] << 7), 2'h0);
            apply(o, c, 1'b1, cy);
            hw = s[0] ? {1'b0, o.c} - {1'b0, o.a} : {1'b0, o.c} + {1'b0, o.a};
            hi = hw[15:0];
            lo = s[0] ? o.d - o.b - cin : o.d + o.b + cin;
            rd(8'h04, {hi, lo}, 2'h0);
            cmp32(result, {hi, lo});
            cmp1(cco, hw[16]);
        end
        wr(8'h00, 32'h20, 2'h0);
        o = {$random(seed), $random(seed)};
        c = '0;
        c.upper_accum_load = 1'b1;
        c.lower_accum_load = 1'b1;
        apply(o, c, 1'b1, 2'h0);
        rd(8'h04, {o.c, o.d}, 2'h0);
        c.upper_accum_reset = 1'b1;
        c.lower_accum_hold = 1'b1;
        apply(o, c, 1'b1, 2'h0);
        rd(8'h04, {16'h0, o.d}, 2'h0);
        c.upper_accum_reset = 1'b0;
        c.lower_accum_hold = 1'b0;
        c.lower_accum_reset = 1'b1;
        apply(o, c, 1'b1, 2'h0);
        rd(8'h04, {o.c, 16'h0}, 2'h0);
        p = {$random(seed), $random(seed)};
        c.upper_accum_hold = 1'b1;
        apply(p, c, 1'b1, 2'h0);
        rd(8'h04, {o.c, 16'h0}, 2'h0);
        apply(p, z, 1'b0, 2'h3);
        rd(8'h04, {o.c, 16'h0}, 2'h0);
        wr(8'h00, 32'hffffe02f, 2'h0);
        rd(8'h00, 32'h2f, 2'h0);
        apply(o, z, 1'b1, 2'h0);
        c = '0;
        c.operand_a_hold = 1'b1;
        c.operand_b_hold = 1'b1;
        c.operand_c_hold = 1'b1;
        c.operand_d_hold = 1'b1;
        apply(p, c, 1'b1, 2'h0);
        apply(p, c, 1'b1, 2'h0);
        hi = o.c + o.a;
        lo = o.d + o.b;
        rd(8'h04, {hi, lo}, 2'h0);
        c.upper_input_reset = 1'b1;
        apply(p, c, 1'b1, 2'h0);
        c.upper_input_reset = 1'b0;
        apply(p, c, 1'b1, 2'h0);
        rd(8'h04, {16'h0, lo}, 2'h0);
        apply(o, z, 1'b1, 2'h0);
        c.lower_input_reset = 1'b1;
        apply(p, c, 1'b1, 2'h0);
        c.lower_input_reset = 1'b0;
        apply(p, c, 1'b1, 2'h0);
        rd(8'h04, {o.a, o.d}, 2'h0);
        wr(8'h00, 32'h0, 2'h0);
        apply(o, z, 1'b1, 2'h0);
        rd(8'h04, o.a * o.b, 2'h0);
        // Accumulate, then pipelined signed multiply-accumulate with chained upper carry
        c = '0;
        c.upper_input_reset = 1'b1;
        c.lower_input_reset = 1'b1;
        c.upper_accum_reset = 1'b1;
        c.lower_accum_reset = 1'b1;
        for (int m = 0; m < 2; m++)
        begin
            wr(8'h00, m ? 32'h1c70 : 32'h40, 2'h0);
            apply(o, c, 1'b1, 2'h0);
            repeat (m ? 4 : 2) apply(o, z, 1'b1, 2'h0);
            sp = $signed(o.a) * $signed(o.b);
            ex = m ? sp + sp : {o.a + o.a, o.b + o.b};
            rd(8'h04, ex, 2'h0);
            cmp32(result, ex);
        end
        report_and_stop();
    end

endmodule

// File: sim/fabric_model.sv
// Fabric-side model that launches operands, controls and carries into the slice
`timescale 1ns/1ps

module fabric_model
(
    input  wire logic                    aclk,
    input  wire logic                    ce_req,
    input  wire slice_pkg::operands_type ops_req,
    input  wire slice_pkg::controls_type ctrl_req,
    input  wire logic [1:0]              carry_req,
    output logic                         clk_enable,
    output slice_pkg::operands_type      ops,
    output slice_pkg::controls_type      ctrl,
    output logic                         cascade_carry_in,
    output logic                         fabric_carry_input
);

    initial
    begin
        clk_enable = 1'b0;
        ops = '0;
        ctrl = '0;
        cascade_carry_in = 1'b0;
        fabric_carry_input = 1'b0;
    end

    // Requests go out one edge after the bench posts them
    always @(posedge aclk)
    begin
        clk_enable <= ce_req;
        ops <= ops_req;
        ctrl <= ctrl_req;
        cascade_carry_in <= carry_req[1];
        fabric_carry_input <= carry_req[0];
    end

endmodule
